//--- rtl/stvl_map.svh
// offsets, field positions, reset values and timing counts of the trip voting block
// assumes: included by bare name; apb data 32 bits, one aligned word per register
//
// What this block does
// - accept trips from flux, pressure, level, valves, discharge header, containment.
// - four flux sub-logics per trip system; each logic takes two of them.
// - each logic gets intermediate and power-range flux; mode picks which one counts.
// - four vessel high-pressure inputs, one per channel, two per trip system.
// - vessel low-level inputs arranged like high-pressure ones, two per trip system.
// - four stop valves, two channels each; either channel alone means closed.
// - stop valve trip only when three or four of four paths closed.
// - stop valve closure trips recirc pump only above the turbine power enable.
// - control valve fast closure trips only above the power enable, else ignored.
// - hydraulic controller drives fast closure; it also trips the recirc pump.
// - isolation lines route: A to A1,B1; B to A1,B2; C to A2,B1; D to A2,B2.
// - eight isolation valves, two channels each; either channel alone means closed.
// - logic trips on isolation only with a closed valve in both its lines.
// - any logic trips its own trip system; no shutdown without the other system.
// - two valves or two lines never shut down; three or four lines do.
// - isolation closure trip works only in run mode, masked otherwise.
// - shutdown needs one tripped logic in system A and one in system B.
// - protective action latches and clears only on operator reset.
// - with full shutdown present, refuse reset for ten seconds after it starts; power-up and single trips reset at once.
// - a tripped system de-energizes its actuator output; energized means not tripped.
`ifndef STVL_MAP_SVH
`define STVL_MAP_SVH

// register byte offsets
`define STVL_CTRL_OFS 12'h000
`define STVL_STATUS_OFS 12'h004
`define STVL_EVENT_OFS 12'h008
`define STVL_CAUSE_OFS 12'h00c

// control field positions
`define STVL_CTRL_MODE_LSB 0
`define STVL_CTRL_OPRST_BIT 8
`define STVL_CTRL_RESET 32'h0000_0000

// event bits (write one to clear)
`define STVL_EVT_REFUSED_BIT 0
`define STVL_EVT_SCRAM_BIT 1

// cause bit positions within a logic's byte
`define STVL_C_FLUX 0
`define STVL_C_HIPRESS 1
`define STVL_C_LOLEVEL 2
`define STVL_C_STOPV 3
`define STVL_C_CTRLV 4
`define STVL_C_ISOV 5
`define STVL_C_DISCH 6
`define STVL_C_CONTAIN 7

// timing: reset hold-off after a full shutdown
`define STVL_HOLD_TIME_S 10
`define STVL_CLK_HZ 10000000

`endif

//--- rtl/stvl_pkg.sv
// types shared by the trip voting block
// assumes: contact inputs high while closed (normal), low when opened (tripped)
package stvl_pkg;

  // reactor mode selection
  typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_REFUEL, MODE_STARTUP, MODE_RUN} stvl_mode_t;

  // all sensor contacts, one bit per channel
  typedef struct packed {
    logic [3:0] turbPowerEnable;  // high: first-stage pressure above threshold
    logic [3:0] containHighPress;
    logic [3:0] dischargeHigh;
    logic [15:0] isoValveCh;      // line*4 + valve*2 + channel
    logic [3:0] ctrlValveFast;
    logic [7:0] stopValveCh;      // valve*2 + channel
    logic [3:0] vesselLowLevel;
    logic [3:0] vesselHighPress;
    logic [7:0] fluxPowerRange;   // power_range_flux_voter per sub-logic
    logic [7:0] fluxIntermediate; // intermediate_range_flux_channel per sub-logic
  } stvl_contacts_t;

  // trip outputs toward the actuators
  typedef struct packed {
    logic actuatorA;    // high: energized
    logic actuatorB;
    logic scram;
    logic recircPumpTripA;
    logic recircPumpTripB;
  } stvl_trip_out_t;

endpackage : stvl_pkg

//--- rtl/stvl_sync.sv
// two-stage synchronizer bank for the sensor contacts
// assumes: inputs are asynchronous pins; reset value is the safe (tripped) level
`timescale 1ns/1ps
module stvl_sync #(
  parameter int WIDTH = 64,
  parameter logic [WIDTH-1:0] SAFE_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1_reg <= SAFE_VAL;
      syncOut <= SAFE_VAL;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end

endmodule : stvl_sync

//--- rtl/stvl_top.sv
// trip voting logic: sensor voting, trip-system latches, apb register slave
// assumes: apb master on clk; sensor contacts asynchronous, high while normal
//
// The register offsets and the APB register port were chosen for this implementation.
`include "stvl_map.svh"
`timescale 1ns/1ps
module stvl_top #(
  parameter int unsigned HOLD_CYCLES = `STVL_HOLD_TIME_S * `STVL_CLK_HZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire stvl_pkg::stvl_contacts_t contactsRaw,
  output stvl_pkg::stvl_trip_out_t tripOut
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES);
  // safe level: every contact opened, power enable asserted so gated trips stay armed
  localparam stvl_pkg::stvl_contacts_t SAFE = '{turbPowerEnable: 4'hf, default: '0};

  // ********************************************
  // functions
  // ********************************************

  // a valve is closed when either of its two channels has opened
  function automatic logic valveClosed(input logic [1:0] ch);
    valveClosed = ~(ch[0] & ch[1]);
  endfunction : valveClosed

  // three or four of four set
  function automatic logic atLeastThree(input logic [3:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++)
      n = n + {2'h0, v[i]};
    atLeastThree = (n >= 3'h3);
  endfunction : atLeastThree

  // ********************************************
  // input synchronizers
  // ********************************************

  stvl_pkg::stvl_contacts_t contactsSync;

  stvl_sync #(
    .WIDTH($bits(stvl_pkg::stvl_contacts_t)),
    .SAFE_VAL(SAFE)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .asyncIn(contactsRaw),
    .syncOut(contactsSync)
  );

  // ********************************************
  // registers and bus decode
  // ********************************************

  stvl_pkg::stvl_mode_t mode_reg;
  logic opReset_reg;
  logic [1:0] event_reg;
  logic [1:0] event_next;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [3:0] logicLatch_reg;
  logic [3:0] logicLatch_next;
  logic [1:0] pumpLatch_reg;
  logic [1:0] pumpLatch_next;
  logic [HW-1:0] holdCount_reg;
  logic scramPrev_reg;
  logic [3:0] logicTripRaw;
  logic [3:0] pumpTripRaw;
  logic [31:0] causeVec;
  logic [3:0] lineClosed;
  logic [3:0] stopClosed;
  logic stopVote;
  logic sysTripA;
  logic sysTripB;
  logic scramNow;
  logic holdActive;
  logic resetAccept;
  logic resetRefused;
  logic wrAccess;
  logic setupPhase;
  logic addrHit;

  assign wrAccess = psel & penable & pwrite;
  assign setupPhase = psel & ~penable;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign addrHit = (paddr == `STVL_CTRL_OFS) | (paddr == `STVL_STATUS_OFS) |
                   (paddr == `STVL_EVENT_OFS) | (paddr == `STVL_CAUSE_OFS);

  // mode field; operator reset is a self-clearing one-cycle pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_reg <= stvl_pkg::MODE_SHUTDOWN;
      opReset_reg <= 1'b0;
    end
    else
    begin
      opReset_reg <= wrAccess & (paddr == `STVL_CTRL_OFS) & pwdata[`STVL_CTRL_OPRST_BIT];
      if (wrAccess && paddr == `STVL_CTRL_OFS)
        mode_reg <= stvl_pkg::stvl_mode_t'(pwdata[`STVL_CTRL_MODE_LSB +: 2]);
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  always_comb
  begin
    event_next = event_reg;
    if (wrAccess && paddr == `STVL_EVENT_OFS)
      event_next = event_reg & ~pwdata[1:0];
    event_next[`STVL_EVT_REFUSED_BIT] = event_next[`STVL_EVT_REFUSED_BIT] | resetRefused;
    event_next[`STVL_EVT_SCRAM_BIT] = event_next[`STVL_EVT_SCRAM_BIT] | (scramNow & ~scramPrev_reg);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      event_reg <= 2'h0;
    else
      event_reg <= event_next;
  end

  // read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setupPhase)
    begin
      pslverr_reg <= ~addrHit;
      case (paddr)
        `STVL_CTRL_OFS: prdata_reg <= {30'h0, mode_reg};
        `STVL_STATUS_OFS: prdata_reg <= {22'h0, holdActive, pumpLatch_reg, scramNow,
                                          sysTripB, sysTripA, logicLatch_reg};
        `STVL_EVENT_OFS: prdata_reg <= {30'h0, event_reg};
        `STVL_CAUSE_OFS: prdata_reg <= causeVec;
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************
  // voting
  // ********************************************

  // steam paths: stop valves and isolation lines
  always_comb
  begin
    for (int v = 0; v < 4; v++)
      stopClosed[v] = valveClosed(contactsSync.stopValveCh[2*v +: 2]);
    for (int l = 0; l < 4; l++)
      lineClosed[l] = valveClosed(contactsSync.isoValveCh[4*l +: 2]) |
                      valveClosed(contactsSync.isoValveCh[4*l+2 +: 2]);
  end

  assign stopVote = atLeastThree(stopClosed);

  // per logic causes; logic index 0..3 is A1, A2, B1, B2 and also the channel index
  always_comb
  begin
    logic [1:0] lineA;
    logic [1:0] lineB;
    logic [1:0] fluxSub;
    logic pwrEn;
    lineA = 2'd0;
    lineB = 2'd1;
    fluxSub = 2'h0;
    pwrEn = 1'b0;
    causeVec = 32'h0000_0000;
    pumpTripRaw = 4'h0;
    for (int g = 0; g < 4; g++)
    begin
      // isolation line pairs per logic
      case (g)
        0: begin lineA = 2'd0; lineB = 2'd1; end
        1: begin lineA = 2'd2; lineB = 2'd3; end
        2: begin lineA = 2'd0; lineB = 2'd2; end
        default: begin lineA = 2'd1; lineB = 2'd3; end
      endcase
      // each sub-logic passes power-range in run mode, intermediate range otherwise
      for (int s = 0; s < 2; s++)
        fluxSub[s] = (mode_reg == stvl_pkg::MODE_RUN) ?
                     ~contactsSync.fluxPowerRange[2*g+s] : ~contactsSync.fluxIntermediate[2*g+s];
      pwrEn = contactsSync.turbPowerEnable[g];
      causeVec[8*g + `STVL_C_FLUX] = |fluxSub;
      causeVec[8*g + `STVL_C_HIPRESS] = ~contactsSync.vesselHighPress[g];
      causeVec[8*g + `STVL_C_LOLEVEL] = ~contactsSync.vesselLowLevel[g];
      causeVec[8*g + `STVL_C_STOPV] = stopVote & pwrEn;
      causeVec[8*g + `STVL_C_CTRLV] = ~contactsSync.ctrlValveFast[g] & pwrEn;
      causeVec[8*g + `STVL_C_ISOV] = lineClosed[lineA] & lineClosed[lineB] &
                                     (mode_reg == stvl_pkg::MODE_RUN);
      causeVec[8*g + `STVL_C_DISCH] = ~contactsSync.dischargeHigh[g];
      causeVec[8*g + `STVL_C_CONTAIN] = ~contactsSync.containHighPress[g];
      pumpTripRaw[g] = (stopVote | ~contactsSync.ctrlValveFast[g]) & pwrEn;
    end
  end

  always_comb
  begin
    for (int g = 0; g < 4; g++)
      logicTripRaw[g] = |causeVec[8*g +: 8];
  end

  // ********************************************
  // latches, reset hold-off, outputs
  // ********************************************

  // one-out-of-two per system, both systems for a shutdown
  assign sysTripA = logicLatch_reg[0] | logicLatch_reg[1];
  assign sysTripB = logicLatch_reg[2] | logicLatch_reg[3];
  assign scramNow = sysTripA & sysTripB;
  assign holdActive = (holdCount_reg != '0);
  // single-system trips reset at once; a full shutdown waits out the hold
  assign resetRefused = opReset_reg & scramNow & holdActive;
  assign resetAccept = opReset_reg & ~resetRefused;

  // a present trip condition wins over a reset, so reset only clears cleared causes
  assign logicLatch_next = logicTripRaw | (logicLatch_reg & ~{4{resetAccept}});
  assign pumpLatch_next = {|pumpTripRaw[3:2], |pumpTripRaw[1:0]} |
                          (pumpLatch_reg & ~{2{resetAccept}});

  // power-up comes up tripped and waits for an operator reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      logicLatch_reg <= 4'hf;
      pumpLatch_reg <= 2'h3;
    end
    else
    begin
      logicLatch_reg <= logicLatch_next;
      pumpLatch_reg <= pumpLatch_next;
    end
  end

  // hold-off counter starts on the shutdown edge; idle after reset so power-up can be reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      holdCount_reg <= '0;
      scramPrev_reg <= 1'b1;
    end
    else
    begin
      scramPrev_reg <= scramNow;
      if (scramNow && !scramPrev_reg)
        holdCount_reg <= HOLD_LOAD;
      else if (holdActive)
        holdCount_reg <= holdCount_reg - HW'(1);
    end
  end

  // outputs registered from the latches; energized means not tripped
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tripOut <= '{actuatorA: 1'b0, actuatorB: 1'b0, scram: 1'b1, recircPumpTripA: 1'b1,
                   recircPumpTripB: 1'b1};
    else
      tripOut <= '{actuatorA: ~sysTripA, actuatorB: ~sysTripB, scram: scramNow,
                   recircPumpTripA: pumpLatch_reg[0], recircPumpTripB: pumpLatch_reg[1]};
  end

  // ********************************************
  // assertions
  // ********************************************

  // a reset accepted once the cause has gone may clear the latch on the second edge
  trip_latches_a: assert property (@(posedge clk) disable iff (reset)
    logicTripRaw[0] |=> logicLatch_reg[0] ##1 (logicLatch_reg[0] || $past(resetAccept)))
    else $error("logic trip not latched");
  latch_holds_a: assert property (@(posedge clk) disable iff (reset)
    (logicLatch_reg[2] && !opReset_reg) |=> logicLatch_reg[2]) else $error("latch dropped without reset");
  one_of_two_a: assert property (@(posedge clk) disable iff (reset)
    logicLatch_reg[1] |=> !tripOut.actuatorA) else $error("actuator A energized with tripped logic");
  two_systems_a: assert property (@(posedge clk) disable iff (reset)
    (!sysTripB) |=> !tripOut.scram) else $error("shutdown with system B clear");
  hold_window_a: assert property (@(posedge clk) disable iff (reset)
    $rose(scramNow) |=> holdActive [*8]) else $error("hold-off not started");
  refuse_reset_a: assert property (@(posedge clk) disable iff (reset)
    resetRefused |=> scramNow) else $error("reset accepted during hold-off");
  iso_run_only_a: assert property (@(posedge clk) disable iff (reset)
    (mode_reg != stvl_pkg::MODE_RUN) |-> !causeVec[8 + `STVL_C_ISOV]) else $error("isolation trip outside run");
  ctrl_enable_a: assert property (@(posedge clk) disable iff (reset)
    !contactsSync.turbPowerEnable[0] |-> !causeVec[`STVL_C_CTRLV]) else $error("fast closure trip while bypassed");
  stop_vote_a: assert property (@(posedge clk) disable iff (reset)
    (stopClosed == 4'h3) |-> !stopVote) else $error("two stop valves caused a vote");
  sync_depth_a: assert property (@(posedge clk) disable iff (reset)
    $past(reset, 2) == 1'b0 |-> contactsSync == $past(contactsRaw, 2)) else $error("synchronizer depth wrong");
  pump_trip_a: assert property (@(posedge clk) disable iff (reset)
    pumpTripRaw[3] |=> ##1 tripOut.recircPumpTripB) else $error("recirc pump trip missing");

  scram_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(tripOut.scram));
  refused_seen_c: cover property (@(posedge clk) disable iff (reset) resetRefused);
  accept_seen_c: cover property (@(posedge clk) disable iff (reset) resetAccept && !logicTripRaw[0]);
  iso_seen_c: cover property (@(posedge clk) disable iff (reset) causeVec[16 + `STVL_C_ISOV]);

endmodule : stvl_top

//--- dv/stvl_sensor_model.sv
// sensor side model: valve position switches, trip units and flux channels
// assumes: the bench says which switches have opened; contacts read high while normal
`timescale 1ns/1ps
module stvl_sensor_model (
  input wire stvl_pkg::stvl_contacts_t openMask,
  input wire logic [3:0] powerAbove,
  output stvl_pkg::stvl_contacts_t contactsRaw
);
  // an opened switch pulls its contact low; the bench opens it early in the stroke
  always_comb
  begin
    contactsRaw = ~openMask;
    contactsRaw.turbPowerEnable = powerAbove; // power enable is a level, not a contact that opens
  end
endmodule : stvl_sensor_model

//--- dv/stvl_top_test.sv
// self-checking bench for the trip voting block: apb master, sensor model, voting checks
// assumes: zero-wait apb slave; hold-off shortened to HOLD cycles
`timescale 1ns/1ps
module stvl_top_test;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  stvl_pkg::stvl_contacts_t openMask = '0, contactsRaw;
  stvl_pkg::stvl_contacts_t nm;
  stvl_pkg::stvl_trip_out_t tripOut;
  logic [3:0] powerAbove = 4'h0;
  logic [1:0] mode;
  logic [31:0] r;
  int errors = 0, samples_checked = 0, seed = 57934;

  always #50 clk = ~clk;

  stvl_top #(.HOLD_CYCLES(HOLD)) u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .contactsRaw(contactsRaw), .tripOut(tripOut));
  stvl_sensor_model u_sensors (.openMask(openMask), .powerAbove(powerAbove), .contactsRaw(contactsRaw));

  // ****************************************
  // bus and check helpers
  // ****************************************
  // one apb transfer; request held until pready is seen high
  // a hung slave is left to the watchdog
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // operator reset pulse with the mode kept; outputs follow two edges later
  task automatic op_reset();
    apb(1'b1, 12'h000, {23'h0, 1'b1, 6'h0, mode});
    settle(4);
  endtask : op_reset

  // live causes per logic byte, worked out from the contact levels and mode
  function automatic logic [31:0] exp_cause(input stvl_pkg::stvl_contacts_t c, input logic [1:0] m);
    logic [31:0] e;
    logic [3:0] ln, iso;
    int ns;
    ns = 0;
    // a compare keeps the count one bit wide per valve
    for (int v = 0; v < 4; v++)
      ns += (c.stopValveCh[2*v +: 2] != 2'h3);
    for (int l = 0; l < 4; l++)
      ln[l] = ~&c.isoValveCh[4*l +: 4];
    iso = {ln[1] & ln[3], ln[0] & ln[2], ln[2] & ln[3], ln[0] & ln[1]};
    for (int g = 0; g < 4; g++)
    begin
      e[8*g] = (m == stvl_pkg::MODE_RUN) ? ~&c.fluxPowerRange[2*g +: 2] : ~&c.fluxIntermediate[2*g +: 2];
      e[8*g+1] = ~c.vesselHighPress[g];
      e[8*g+2] = ~c.vesselLowLevel[g];
      e[8*g+3] = (ns >= 3) & c.turbPowerEnable[g];
      e[8*g+4] = ~c.ctrlValveFast[g] & c.turbPowerEnable[g];
      e[8*g+5] = iso[g] & (m == stvl_pkg::MODE_RUN);
      e[8*g+6] = ~c.dischargeHigh[g];
      e[8*g+7] = ~c.containHighPress[g];
    end
    return e;
  endfunction : exp_cause

  task automatic wrap_up();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    mode = 2'h3;
    settle(12);
    reset <= 1'b0;
    settle(1);
    chk({27'h0, tripOut}, 32'h07, "tripped after reset");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "ctrl reset value");
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped access");
    apb(1'b1, 12'h000, 32'h3);
    op_reset();
    chk({27'h0, tripOut}, 32'h18, "energized after reset");
    // single channel: own system only, latched, clears at once
    openMask.containHighPress[0] <= 1'b1;
    settle(2);
    chk({27'h0, tripOut}, 32'h18, "sync delay");
    settle(3);
    chk({27'h0, tripOut}, 32'h08, "system a only");
    openMask <= '0;
    settle(5);
    chk({27'h0, tripOut}, 32'h08, "latched");
    op_reset();
    chk({27'h0, tripOut}, 32'h18, "single reset");
    // fast closure above and below the power enable
    powerAbove <= 4'hf;
    openMask.ctrlValveFast[2] <= 1'b1;
    settle(5);
    chk({27'h0, tripOut}, 32'h11, "fast closure b");
    openMask <= '0;
    powerAbove <= 4'h0;
    settle(5);
    op_reset();
    openMask <= '{ctrlValveFast: 4'h1, stopValveCh: 8'h15, default: '0};
    settle(5);
    chk({27'h0, tripOut}, 32'h18, "low power ignored");
    // full shutdown, hold-off refusal, then release
    openMask <= '{containHighPress: 4'h5, default: '0};
    settle(5);
    chk({27'h0, tripOut}, 32'h04, "shutdown");
    openMask <= '0;
    settle(5);
    op_reset();
    chk({27'h0, tripOut}, 32'h04, "refused in hold");
    // logics 0 and 2 latched, both systems, shutdown, hold-off still running
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h275, "status in hold");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h3, "events");
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0, "events cleared");
    settle(HOLD + 5);
    op_reset();
    chk({27'h0, tripOut}, 32'h18, "reset after hold");
    // three stop valves above the enable: every logic, shutdown and both pump trips
    powerAbove <= 4'hf;
    openMask <= '{stopValveCh: 8'h2a, default: '0};
    settle(5);
    chk({27'h0, tripOut}, 32'h07, "stop valves above enable");
    openMask <= '0;
    powerAbove <= 4'h0;
    settle(HOLD + 5);
    op_reset();
    chk({27'h0, tripOut}, 32'h18, "pump trips reset");
    // random contact patterns against the live cause register
    for (int i = 0; i < 60; i++)
    begin
      // pattern built whole, then driven once
      r = $random(seed);
      mode = r[1:0];
      powerAbove <= r[7:4];
      nm = '0;
      r = $random(seed) & $random(seed);
      nm.fluxPowerRange = r[7:0];
      nm.fluxIntermediate = r[15:8];
      r = $random(seed) & $random(seed) & $random(seed);
      {nm.vesselHighPress, nm.vesselLowLevel, nm.ctrlValveFast} = r[11:0];
      {nm.dischargeHigh, nm.containHighPress} = r[19:12];
      for (int v = 0; v < 4; v++)
      begin
        r = $random(seed);
        nm.stopValveCh[2*v +: 2] = r[0] ? ((r[2:1] == 2'h0) ? 2'h1 : r[2:1]) : 2'h0;
        nm.isoValveCh[4*v +: 4] = r[4] ? ((r[6:5] == 2'h0 ? 4'h1 : {2'h0, r[6:5]}) << (2 * r[7])) : 4'h0;
      end
      openMask <= nm;
      apb(1'b1, 12'h000, {30'h0, mode});
      settle(4);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, exp_cause(contactsRaw, mode), "live causes");
    end
    wrap_up();
  end

  // cut a hang short
  initial
  begin
    #2000000;
    errors++;
    wrap_up();
  end
endmodule : stvl_top_test
